/* cmw_clock_ctrl.sv */
// CPU clock mode selection, clock switching and oscillator watchdog control
//
// Behaviour
// R1 - Straps are caught at reset and fix the clock mode until next reset.
// R2 - Every strap code except 001 and 011 enables the PLL as CPU clock source.
// R3 - PLL factor: 111 x4, 110 x3, 101 x8, 100 x5, 010 x10, 000 x16.
// R4 - Each PLL code sets its input divider, VCO multiplier and output divider.
// R5 - Outside party keeps the VCO frequency between 64 and 128 MHz.
// R6 - Code 001 divides the oscillator by two; half period equals input period.
// R7 - Code 011 bypasses PLL and amplifier, drives CPU clock from input pin.
// R8 - Direct drive halves follow input duty; two halves equal one input period.
// R9 - Outside party feeds an external clock only in direct drive mode.
// R10 - Both CPU clock edges trigger operations; each half period is the unit.
// R11 - Oscillator watchdog works only in direct drive or prescaler mode.
// R12 - Watchdog enabled after reset; the disable flag turns it off.
// R13 - Flag clear: PLL free-runs to clock watchdog; flag set: PLL off.
// R14 - Watchdog counter counts PLL clocks, clears on every input transition.
// R15 - Missing input transitions make the counter overflow after 16 PLL clocks.
// R16 - Overflow moves the CPU clock to the PLL clock and flags an interrupt.
// R17 - After switchover the backup clock stays until the next reset.
// R18 - Watchdog disabled: CPU clock from oscillator path, PLL powered down.
// R19 - PLL unlock raises an interrupt, disconnects reference until reset.
// R20 - Switch to the backup clock never shortens a CPU clock phase.
`timescale 1ns/10ps
`default_nettype none
module cmw_clock_ctrl
    import cmw_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Pins from outside the clock domain
    input wire logic [2:0] CLOCK_MODE_STRAPS,
    input wire logic OSC_INPUT_PIN,
    input wire logic PLL_CLK_IN,
    input wire logic PLL_LOCKED,
    // System configuration
    input wire logic OSC_WATCHDOG_DISABLE,
    input wire logic OSC_WDOG_IRQ_CLR,
    input wire logic PLL_UNLOCK_IRQ_CLR,
    // CPU clock
    output logic CPU_CLK,
    output logic CPU_CLK_EDGE,
    output logic CLOCK_READY,
    output cmw_src_t CLOCK_SOURCE,
    // PLL and oscillator control
    output cmw_pll_cfg_t PLL_CFG,
    output cmw_status_t CLOCK_STATUS,
    output logic [2:0] CLOCK_MODE,
    // Interrupt requests
    output logic OSC_WDOG_IRQ,
    output logic PLL_UNLOCK_IRQ
);

    // Synchronised pins
    logic [CMW_SYNC_W-1:0] sync_level;
    wire logic lock_s;
    wire logic pll_s;
    wire logic osc_s;
    wire logic [2:0] straps_s;

    // Edge history
    logic osc_prev_reg;
    logic pll_prev_reg;
    wire logic osc_edge;
    wire logic osc_rise;
    wire logic pll_edge;

    // Strap capture
    logic [CMW_SETTLE_W-1:0] settle_reg;
    logic [CMW_SETTLE_W-1:0] settle_next;
    logic [2:0] mode_reg;
    logic ready_reg;
    wire logic settling;
    wire logic settle_done;

    // Source selection
    cmw_src_t src_reg;
    cmw_src_t src_next;
    cmw_src_t src_run;
    wire logic mode_direct;
    wire logic mode_prescale;
    wire logic mode_pll;

    // Watchdog and unlock
    wire logic wdog_enable;
    wire logic wdog_ovf;
    wire logic switch_backup;
    logic lock_seen_reg;
    logic unlock_reg;
    wire logic unlock_event;

    // CPU clock generation
    logic cpu_clk_reg;
    logic cpu_edge_reg;
    wire logic clk_toggle;

    // Control outputs
    cmw_status_t status_reg;
    cmw_status_t status_next;
    cmw_pll_cfg_t cfg_reg;
    cmw_pll_cfg_t cfg_next;
    logic wdog_irq_reg;
    logic unlock_irq_reg;

    cmw_sync3 #(
        .W(CMW_SYNC_W)
    ) u_sync (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .pin_in({CLOCK_MODE_STRAPS, OSC_INPUT_PIN, PLL_CLK_IN, PLL_LOCKED}),
        .level_out(sync_level)
    );

    assign lock_s = sync_level[CMW_LANE_LOCK];
    assign pll_s = sync_level[CMW_LANE_PLLCLK];
    assign osc_s = sync_level[CMW_LANE_OSC];
    assign straps_s = sync_level[CMW_LANE_STRAP +: 3];

    // Transitions of the input clock and the PLL clock
    assign osc_edge = osc_s != osc_prev_reg;
    assign osc_rise = osc_s && !osc_prev_reg;
    assign pll_edge = pll_s != pll_prev_reg;

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            osc_prev_reg <= 1'b0;
            pll_prev_reg <= 1'b0;
        end
        else
        begin
            osc_prev_reg <= osc_s;
            pll_prev_reg <= pll_s;
        end
    end

    // Straps are sampled after reset release until the synchroniser has settled,
    // then frozen until the next reset
    assign settling = !ready_reg;
    assign settle_done = settling && (settle_reg == CMW_SETTLE_LAST);
    assign settle_next = settling ? settle_reg + CMW_SETTLE_ONE : settle_reg;

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            settle_reg <= '0;
            mode_reg <= CMW_STRAP_RESET;
            ready_reg <= 1'b0;
        end
        else
        begin
            settle_reg <= settle_next;
            if (settling)
            begin
                mode_reg <= straps_s; // [R1]
            end
            if (settle_done)
            begin
                ready_reg <= 1'b1; // [R1]
            end
        end
    end

    // Mode decode
    assign mode_direct = mode_reg == CMW_MODE_DIRECT;
    assign mode_prescale = mode_reg == CMW_MODE_PRESCALE;
    assign mode_pll = !mode_direct && !mode_prescale; // [R2]

    always_comb
    begin
        if (mode_direct)
        begin
            src_run = CMW_SRC_DIRECT; // [R7]
        end
        else if (mode_prescale)
        begin
            src_run = CMW_SRC_PRESCALE; // [R6]
        end
        else
        begin
            src_run = CMW_SRC_PLL; // [R2]
        end
    end

    // Watchdog runs only on the oscillator paths and only while not disabled
    assign wdog_enable = ((src_reg == CMW_SRC_DIRECT) || (src_reg == CMW_SRC_PRESCALE))
                      && !OSC_WATCHDOG_DISABLE; // [R11] [R12]

    cmw_osc_watchdog u_wdog (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .enable(wdog_enable),
        .pll_tick(pll_edge && pll_s),
        .osc_edge(osc_edge),
        .overflow(wdog_ovf)
    );

    assign switch_backup = wdog_ovf && wdog_enable; // [R16]

    // Source state: backup is a trap left only by reset
    always_comb
    begin
        case (src_reg)
            CMW_SRC_HOLD:
            begin
                src_next = settle_done ? src_run : CMW_SRC_HOLD;
            end
            CMW_SRC_DIRECT, CMW_SRC_PRESCALE:
            begin
                src_next = switch_backup ? CMW_SRC_BACKUP : src_reg; // [R16]
            end
            CMW_SRC_PLL:
            begin
                src_next = CMW_SRC_PLL;
            end
            CMW_SRC_BACKUP:
            begin
                src_next = CMW_SRC_BACKUP; // [R17]
            end
            default:
            begin
                src_next = CMW_SRC_HOLD;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            src_reg <= CMW_SRC_HOLD;
        end
        else
        begin
            src_reg <= src_next;
        end
    end

    // The CPU clock register only toggles on an event of the selected source.
    // A failed input has already stretched the running phase, and the backup
    // path waits for a PLL edge before its first toggle, so no phase is cut.
    assign clk_toggle = ((src_reg == CMW_SRC_DIRECT) && osc_edge)        // [R8]
                     || ((src_reg == CMW_SRC_PRESCALE) && osc_rise)      // [R6]
                     || ((src_reg == CMW_SRC_PLL) && pll_edge)           // [R3]
                     || ((src_reg == CMW_SRC_BACKUP) && pll_edge);       // [R20]

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cpu_clk_reg <= 1'b0;
            cpu_edge_reg <= 1'b0;
        end
        else
        begin
            cpu_clk_reg <= cpu_clk_reg ^ clk_toggle;
            cpu_edge_reg <= clk_toggle; // [R10]
        end
    end

    // Loss of lock in PLL mode, counted once the PLL has locked
    assign unlock_event = (src_reg == CMW_SRC_PLL) && lock_seen_reg && !lock_s
                       && !unlock_reg; // [R19]

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            lock_seen_reg <= 1'b0;
            unlock_reg <= 1'b0;
        end
        else
        begin
            if ((src_reg == CMW_SRC_PLL) && lock_s)
            begin
                lock_seen_reg <= 1'b1;
            end
            if (unlock_event)
            begin
                unlock_reg <= 1'b1; // [R19]
            end
        end
    end

    // PLL and oscillator control
    always_comb
    begin
        status_next.pll_enable = (src_reg == CMW_SRC_PLL)                    // [R2]
                              || (src_reg == CMW_SRC_BACKUP)                 // [R16]
                              || (wdog_enable && !switch_backup)             // [R13]
                              || (switch_backup);
        status_next.ref_connect = (src_reg == CMW_SRC_PLL) && !unlock_reg
                               && !unlock_event;                             // [R19]
        status_next.osc_amp_bypass = mode_direct && (src_reg != CMW_SRC_HOLD); // [R7] [R9]
        status_next.wdog_active = wdog_enable && !switch_backup;             // [R18]
    end

    assign cfg_next = (mode_pll && (src_reg != CMW_SRC_HOLD))
                    ? cmw_pll_lookup(mode_reg) : CMW_CFG_NONE; // [R3] [R4]

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            status_reg <= '0;
            cfg_reg <= CMW_CFG_NONE;
        end
        else
        begin
            status_reg <= status_next;
            cfg_reg <= cfg_next;
        end
    end

    // Interrupt flags: a new event wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wdog_irq_reg <= 1'b0;
            unlock_irq_reg <= 1'b0;
        end
        else
        begin
            if (switch_backup)
            begin
                wdog_irq_reg <= 1'b1; // [R16]
            end
            else if (OSC_WDOG_IRQ_CLR)
            begin
                wdog_irq_reg <= 1'b0;
            end
            if (unlock_event)
            begin
                unlock_irq_reg <= 1'b1; // [R19]
            end
            else if (PLL_UNLOCK_IRQ_CLR)
            begin
                unlock_irq_reg <= 1'b0;
            end
        end
    end

    // Outputs
    assign CPU_CLK = cpu_clk_reg;
    assign CPU_CLK_EDGE = cpu_edge_reg;
    assign CLOCK_READY = ready_reg;
    assign CLOCK_SOURCE = src_reg;
    assign PLL_CFG = cfg_reg;
    assign CLOCK_STATUS = status_reg;
    assign CLOCK_MODE = mode_reg;
    assign OSC_WDOG_IRQ = wdog_irq_reg;
    assign PLL_UNLOCK_IRQ = unlock_irq_reg;

endmodule : cmw_clock_ctrl
`default_nettype wire

/* cmw_clock_ctrl_properties.sv */
// Port checker for clock mode selection and oscillator watchdog switching
`timescale 1ns/10ps
`default_nettype none
module cmw_clock_ctrl_properties
    import cmw_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Configuration
    input wire logic OSC_WATCHDOG_DISABLE,
    // Observed outputs
    input wire logic CPU_CLK,
    input wire logic CPU_CLK_EDGE,
    input wire logic CLOCK_READY,
    input wire cmw_src_t CLOCK_SOURCE,
    input wire cmw_pll_cfg_t PLL_CFG,
    input wire cmw_status_t CLOCK_STATUS,
    input wire logic [2:0] CLOCK_MODE,
    input wire logic OSC_WDOG_IRQ,
    input wire logic PLL_UNLOCK_IRQ
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);

    // Source chosen one cycle ago and status caught up with it
    sequence s_settled;
        CLOCK_READY && $past(CLOCK_READY) && $stable(CLOCK_SOURCE);
    endsequence

    sequence s_backup_entry;
        $changed(CLOCK_SOURCE) && CLOCK_SOURCE == CMW_SRC_BACKUP;
    endsequence

    a_edge_pulse: assert property (CPU_CLK_EDGE == (CPU_CLK != $past(CPU_CLK)))
        else $error("cpu clock edge flag does not match a clock change");
    a_hold_quiet: assert property (!CLOCK_READY |-> CLOCK_SOURCE == CMW_SRC_HOLD && $stable(CPU_CLK))
        else $error("clock moved before the straps were frozen");
    a_mode_frozen: assert property (s_settled |-> $stable(CLOCK_MODE))
        else $error("captured mode changed after capture");
    a_source_map: assert property ($rose(CLOCK_READY) |-> CLOCK_SOURCE == (CLOCK_MODE == CMW_MODE_DIRECT ? CMW_SRC_DIRECT : CLOCK_MODE == CMW_MODE_PRESCALE ? CMW_SRC_PRESCALE : CMW_SRC_PLL))
        else $error("clock source does not match captured mode");
    a_cfg_ratio: assert property (s_settled ##0 CLOCK_SOURCE == CMW_SRC_PLL |-> PLL_CFG.in_div != 3'h0 && PLL_CFG.vco_mult == PLL_CFG.factor * PLL_CFG.in_div * PLL_CFG.out_div)
        else $error("pll dividers do not give the factor");
    a_backup_sticky: assert property (CLOCK_SOURCE == CMW_SRC_BACKUP |=> CLOCK_SOURCE == CMW_SRC_BACKUP)
        else $error("backup clock left before reset");
    a_backup_cause: assert property (s_backup_entry |-> OSC_WDOG_IRQ && $past(CLOCK_SOURCE) inside {CMW_SRC_DIRECT, CMW_SRC_PRESCALE})
        else $error("backup entered without watchdog overflow");
    a_wdog_power: assert property (s_settled ##0 CLOCK_SOURCE inside {CMW_SRC_DIRECT, CMW_SRC_PRESCALE} && OSC_WATCHDOG_DISABLE == $past(OSC_WATCHDOG_DISABLE) |-> CLOCK_STATUS.pll_enable == !OSC_WATCHDOG_DISABLE && CLOCK_STATUS.wdog_active == !OSC_WATCHDOG_DISABLE)
        else $error("pll power does not follow watchdog disable");
    a_direct_bypass: assert property (s_settled ##0 CLOCK_SOURCE == CMW_SRC_DIRECT |-> CLOCK_STATUS.osc_amp_bypass)
        else $error("amplifier not bypassed in direct drive");
    a_unlock_ref: assert property ($rose(PLL_UNLOCK_IRQ) |-> !CLOCK_STATUS.ref_connect)
        else $error("reference still connected after unlock");
    a_ref_held: assert property (!CLOCK_STATUS.ref_connect && CLOCK_SOURCE == CMW_SRC_PLL && $past(CLOCK_SOURCE) == CMW_SRC_PLL |=> !CLOCK_STATUS.ref_connect)
        else $error("reference reconnected before reset");
endmodule : cmw_clock_ctrl_properties
`default_nettype wire

/* cmw_clock_ctrl_tb.sv */
// Self-checking testbench of the clock mode and oscillator watchdog block
`timescale 1ns/10ps
`default_nettype none
module cmw_clock_ctrl_tb
    import cmw_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] straps = CMW_MODE_X4;
    logic locked = 1'b0;
    logic wdog_dis = 1'b0;
    logic wdog_clr = 1'b0;
    logic unlock_clr = 1'b0;
    logic osc_run = 1'b1;
    logic osc_pin, pll_pin, cpu_clk, cpu_edge, ready, wdog_irq, unlock_irq;
    logic [2:0] mode;
    cmw_src_t src;
    cmw_pll_cfg_t cfg;
    cmw_status_t st;
    int fail_count = 0;
    int num_checks = 0;

    initial forever #10 clk = ~clk;

    cmw_osc_model u_cmw_osc_model (.clk(clk), .osc_run(osc_run), .osc_half(4'h4),
        .pll_half(4'h3), .osc_pin(osc_pin), .pll_pin(pll_pin));
    cmw_clock_ctrl u_cmw_clock_ctrl (.CORE_CLK(clk), .RSTN(rstn), .CLOCK_MODE_STRAPS(straps),
        .OSC_INPUT_PIN(osc_pin), .PLL_CLK_IN(pll_pin), .PLL_LOCKED(locked),
        .OSC_WATCHDOG_DISABLE(wdog_dis), .OSC_WDOG_IRQ_CLR(wdog_clr),
        .PLL_UNLOCK_IRQ_CLR(unlock_clr), .CPU_CLK(cpu_clk), .CPU_CLK_EDGE(cpu_edge),
        .CLOCK_READY(ready), .CLOCK_SOURCE(src), .PLL_CFG(cfg), .CLOCK_STATUS(st),
        .CLOCK_MODE(mode), .OSC_WDOG_IRQ(wdog_irq), .PLL_UNLOCK_IRQ(unlock_irq));

    task automatic chk_val(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_range(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : chk_range

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    task automatic count_edges(input int n, output int cnt);
        cnt = 0;
        repeat (n)
        begin
            cycles(1);
            if (cpu_edge === 1'b1)
                cnt++;
        end
    endtask : count_edges

    task automatic do_reset(input logic [2:0] code, input logic dis);
        int n;
        @(posedge clk);
        rstn <= 1'b0;
        straps <= code;
        wdog_dis <= dis;
        osc_run <= 1'b1;
        locked <= 1'b0;
        cycles(2);
        @(posedge clk) rstn <= 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 20)
        begin
            cycles(1);
            n++;
        end
        chk_range(n, 6, 6);
        cycles(2);
    endtask : do_reset

    function automatic logic [17:0] exp_cfg(input int c);
        case (c)
            7: exp_cfg = {3'h4, 7'h40, 3'h4, 5'h04};
            6: exp_cfg = {3'h4, 7'h30, 3'h4, 5'h03};
            5: exp_cfg = {3'h4, 7'h40, 3'h2, 5'h08};
            4: exp_cfg = {3'h4, 7'h28, 3'h2, 5'h05};
            2: exp_cfg = {3'h2, 7'h28, 3'h2, 5'h0A};
            0: exp_cfg = {3'h2, 7'h40, 3'h2, 5'h10};
            default: exp_cfg = 18'h00000;
        endcase
    endfunction : exp_cfg

    // Every strap code; clock edge rate per mode; late strap change ignored
    task automatic t_modes;
        int cnt;
        int e;
        for (int c = 0; c < 8; c++)
        begin
            do_reset(3'(c), 1'b0);
            e = c == 3 ? 24 : c == 1 ? 12 : 32;
            chk_val(18'(mode), 18'(c));
            chk_val(18'(src), 18'(c == 3 ? CMW_SRC_DIRECT : c == 1 ? CMW_SRC_PRESCALE : CMW_SRC_PLL));
            chk_val(cfg, exp_cfg(c));
            chk_val(18'(st.pll_enable), 18'h1);
            chk_val(18'(st.osc_amp_bypass), 18'(c == 3));
            chk_val(18'(st.wdog_active), 18'(c == 1 || c == 3));
            count_edges(96, cnt);
            chk_range(cnt, e - 1, e + 1);
            @(posedge clk) straps <= ~3'(c);
            cycles(10);
            chk_val(18'(mode), 18'(c));
        end
    endtask : t_modes

    // Oscillator stops in direct and prescaled modes, then recovers
    task automatic t_wdog;
        int n;
        int cnt;
        for (int k = 0; k < 2; k++)
        begin
            do_reset(k == 1 ? CMW_MODE_PRESCALE : CMW_MODE_DIRECT, 1'b0);
            // Stop one cycle after an input transition so 15 or 17 ticks would miss
            @(osc_pin);
            @(posedge clk) osc_run <= 1'b0;
            n = 0;
            while (wdog_irq !== 1'b1 && n < 200)
            begin
                cycles(1);
                n++;
            end
            chk_range(n, 96, 101);
            chk_val(18'(src), 18'(CMW_SRC_BACKUP));
            @(posedge clk) osc_run <= 1'b1;
            count_edges(96, cnt);
            chk_range(cnt, 31, 33);
            chk_val(18'(src), 18'(CMW_SRC_BACKUP));
            @(posedge clk) wdog_clr <= 1'b1;
            @(posedge clk) wdog_clr <= 1'b0;
            cycles(2);
            chk_val(18'(wdog_irq), 18'h0);
        end
    endtask : t_wdog

    // Watchdog disabled: a dead oscillator is never replaced
    task automatic t_disabled;
        do_reset(CMW_MODE_DIRECT, 1'b1);
        @(posedge clk) osc_run <= 1'b0;
        cycles(200);
        chk_val(18'(wdog_irq), 18'h0);
        chk_val(18'(src), 18'(CMW_SRC_DIRECT));
        chk_val(18'(st.pll_enable), 18'h0);
    endtask : t_disabled

    // PLL mode: no watchdog, unlock disconnects the reference for good
    task automatic t_unlock;
        int n;
        do_reset(CMW_MODE_X8, 1'b0);
        @(posedge clk);
        locked <= 1'b1;
        osc_run <= 1'b0;
        cycles(200);
        chk_val(18'(wdog_irq), 18'h0);
        chk_val(18'(st.ref_connect), 18'h1);
        @(posedge clk) locked <= 1'b0;
        n = 0;
        while (unlock_irq !== 1'b1 && n < 20)
        begin
            cycles(1);
            n++;
        end
        chk_range(n, 5, 5);
        chk_val(18'(st.ref_connect), 18'h0);
        chk_val(18'(src), 18'(CMW_SRC_PLL));
        @(posedge clk) locked <= 1'b1;
        @(posedge clk) unlock_clr <= 1'b1;
        @(posedge clk) unlock_clr <= 1'b0;
        cycles(20);
        chk_val(18'(st.ref_connect), 18'h0);
        chk_val(18'(unlock_irq), 18'h0);
    endtask : t_unlock

    initial
    begin
        t_modes();
        t_wdog();
        t_disabled();
        t_unlock();
        summarize();
    end

    initial
    begin
        #200000;
        fail_count++;
        summarize();
    end
endmodule : cmw_clock_ctrl_tb

bind cmw_clock_ctrl cmw_clock_ctrl_properties u_cmw_clock_ctrl_properties (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .OSC_WATCHDOG_DISABLE(OSC_WATCHDOG_DISABLE),
    .CPU_CLK(CPU_CLK), .CPU_CLK_EDGE(CPU_CLK_EDGE), .CLOCK_READY(CLOCK_READY),
    .CLOCK_SOURCE(CLOCK_SOURCE), .PLL_CFG(PLL_CFG), .CLOCK_STATUS(CLOCK_STATUS),
    .CLOCK_MODE(CLOCK_MODE), .OSC_WDOG_IRQ(OSC_WDOG_IRQ), .PLL_UNLOCK_IRQ(PLL_UNLOCK_IRQ));
`default_nettype wire

/* cmw_osc_model.sv */
// Crystal oscillator and free-running PLL clock levels at the clock pins
`timescale 1ns/10ps
`default_nettype none
module cmw_osc_model (
    // Clock
    input wire logic clk,
    // Control
    input wire logic osc_run,
    input wire logic [3:0] osc_half,
    input wire logic [3:0] pll_half,
    // Pins
    output logic osc_pin,
    output logic pll_pin
);
    logic [3:0] osc_cnt_reg = 4'h0;
    logic [3:0] pll_cnt_reg = 4'h0;
    initial osc_pin = 1'b0;
    initial pll_pin = 1'b0;
    // Fixed square wave from a crystal; a stopped crystal freezes its level
    always @(posedge clk)
    begin
        if (osc_run)
        begin
            osc_cnt_reg <= (osc_cnt_reg + 4'h1 >= osc_half) ? 4'h0 : osc_cnt_reg + 4'h1;
            if (osc_cnt_reg + 4'h1 >= osc_half)
                osc_pin <= ~osc_pin;
        end
        pll_cnt_reg <= (pll_cnt_reg + 4'h1 >= pll_half) ? 4'h0 : pll_cnt_reg + 4'h1;
        if (pll_cnt_reg + 4'h1 >= pll_half)
            pll_pin <= ~pll_pin;
    end
endmodule : cmw_osc_model
`default_nettype wire

/* cmw_osc_watchdog.sv */
// Oscillator watchdog counter: counts PLL clocks between input clock transitions
`timescale 1ns/10ps
`default_nettype none
module cmw_osc_watchdog
    import cmw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control and events
    input wire logic enable,
    input wire logic pll_tick,
    input wire logic osc_edge,
    // Result
    output logic overflow
);
    logic [CMW_WDOG_W-1:0] count_reg;
    logic [CMW_WDOG_W-1:0] count_next;
    logic ovf_reg;
    wire logic hit;

    assign hit = pll_tick && ((count_reg + CMW_WDOG_ONE) == CMW_WDOG_OVF);
    assign count_next = (!enable || osc_edge || hit) ? CMW_WDOG_ZERO
                      : pll_tick ? count_reg + CMW_WDOG_ONE
                      : count_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_reg <= CMW_WDOG_ZERO;
            ovf_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next; // [R14]
            ovf_reg <= enable && !osc_edge && hit; // [R15]
        end
    end

    assign overflow = ovf_reg;
endmodule : cmw_osc_watchdog
`default_nettype wire

/* cmw_pkg.sv */
// Constants, types and lookup for the CPU clock mode and oscillator watchdog block
package cmw_pkg;

    // Clock mode strap codes
    localparam logic [2:0] CMW_MODE_X16 = 3'h0;
    localparam logic [2:0] CMW_MODE_PRESCALE = 3'h1;
    localparam logic [2:0] CMW_MODE_X10 = 3'h2;
    localparam logic [2:0] CMW_MODE_DIRECT = 3'h3;
    localparam logic [2:0] CMW_MODE_X5 = 3'h4;
    localparam logic [2:0] CMW_MODE_X8 = 3'h5;
    localparam logic [2:0] CMW_MODE_X3 = 3'h6;
    localparam logic [2:0] CMW_MODE_X4 = 3'h7;
    localparam logic [2:0] CMW_STRAP_RESET = CMW_MODE_X4;

    // Watchdog counter
    localparam int CMW_WDOG_W = 5;
    localparam logic [CMW_WDOG_W-1:0] CMW_WDOG_OVF = 5'h10;
    localparam logic [CMW_WDOG_W-1:0] CMW_WDOG_ZERO = 5'h00;
    localparam logic [CMW_WDOG_W-1:0] CMW_WDOG_ONE = 5'h01;

    // Strap settling after reset release
    localparam int CMW_CLK_PERIOD_NS = 20;
    localparam int CMW_STRAP_SETTLE_NS = 100;
    localparam int CMW_STRAP_SETTLE_CYC =
        (CMW_STRAP_SETTLE_NS + CMW_CLK_PERIOD_NS - 1) / CMW_CLK_PERIOD_NS;
    localparam int CMW_SETTLE_W = 4;
    localparam logic [CMW_SETTLE_W-1:0] CMW_SETTLE_LAST = CMW_SETTLE_W'(CMW_STRAP_SETTLE_CYC);
    localparam logic [CMW_SETTLE_W-1:0] CMW_SETTLE_ONE = 4'h1;

    // Synchroniser lane positions
    localparam int CMW_SYNC_W = 6;
    localparam int CMW_LANE_LOCK = 0;
    localparam int CMW_LANE_PLLCLK = 1;
    localparam int CMW_LANE_OSC = 2;
    localparam int CMW_LANE_STRAP = 3;

    typedef enum logic [2:0] {
        CMW_SRC_HOLD,
        CMW_SRC_PLL,
        CMW_SRC_DIRECT,
        CMW_SRC_PRESCALE,
        CMW_SRC_BACKUP
    } cmw_src_t;

    typedef struct packed {
        logic [2:0] in_div;
        logic [6:0] vco_mult;
        logic [2:0] out_div;
        logic [4:0] factor;
    } cmw_pll_cfg_t;

    typedef struct packed {
        logic pll_enable;
        logic ref_connect;
        logic osc_amp_bypass;
        logic wdog_active;
    } cmw_status_t;

    localparam cmw_pll_cfg_t CMW_CFG_NONE = '{3'h0, 7'h00, 3'h0, 5'h00};
    localparam cmw_pll_cfg_t CMW_CFG_X4 = '{3'h4, 7'h40, 3'h4, 5'h04};
    localparam cmw_pll_cfg_t CMW_CFG_X3 = '{3'h4, 7'h30, 3'h4, 5'h03};
    localparam cmw_pll_cfg_t CMW_CFG_X8 = '{3'h4, 7'h40, 3'h2, 5'h08};
    localparam cmw_pll_cfg_t CMW_CFG_X5 = '{3'h4, 7'h28, 3'h2, 5'h05};
    localparam cmw_pll_cfg_t CMW_CFG_X10 = '{3'h2, 7'h28, 3'h2, 5'h0A};
    localparam cmw_pll_cfg_t CMW_CFG_X16 = '{3'h2, 7'h40, 3'h2, 5'h10};

    function automatic cmw_pll_cfg_t cmw_pll_lookup(input logic [2:0] mode);
        case (mode)
            CMW_MODE_X4: cmw_pll_lookup = CMW_CFG_X4;
            CMW_MODE_X3: cmw_pll_lookup = CMW_CFG_X3;
            CMW_MODE_X8: cmw_pll_lookup = CMW_CFG_X8;
            CMW_MODE_X5: cmw_pll_lookup = CMW_CFG_X5;
            CMW_MODE_X10: cmw_pll_lookup = CMW_CFG_X10;
            CMW_MODE_X16: cmw_pll_lookup = CMW_CFG_X16;
            default: cmw_pll_lookup = CMW_CFG_NONE;
        endcase
    endfunction : cmw_pll_lookup

endpackage : cmw_pkg

/* cmw_sync3.sv */
// Three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module cmw_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pins and result
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_lane
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    s1_reg[g] <= 1'b0;
                    s2_reg[g] <= 1'b0;
                    s3_reg[g] <= 1'b0;
                    out_reg[g] <= 1'b0;
                end
                else
                begin
                    s1_reg[g] <= pin_in[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    if (s2_reg[g] == s3_reg[g])
                    begin
                        out_reg[g] <= s3_reg[g];
                    end
                end
            end
        end
    endgenerate

    assign level_out = out_reg;
endmodule : cmw_sync3
`default_nettype wire
